// *** tb/tmoc_timer_core_tb.sv ***
// Self-checking testbench for the compare timer core
`timescale 1ns/1ps
module tmoc_timer_core_tb;
  import tmoc_pkg::*;
  logic              mclk;
  logic              reset;
  logic [9:0]        avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_writedata;
  logic [3:0]        avs_byteenable;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic [3:0]        captureEdge;
  tmoc_misc_events_t miscEvents;
  logic [4:0]        portAOut;
  logic [4:0]        portAOe;
  logic              timerIrq;
  int                n_errors;
  int                n_tests;
  int                cyc;
  logic [7:0]        rd;

  tmoc_timer_core dut (.mclk(mclk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .captureEdge(captureEdge), .miscEvents(miscEvents),
    .portAOut(portAOut), .portAOe(portAOe), .timerIrq(timerIrq));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic close_out;
    $display("checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Ceiling covers one full counter wrap plus the short tests
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 100000) begin
      n_errors++;
      $display("[FAIL] %0t timeout", $time);
      close_out();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Values sampled in the active region at the edge are the pre-edge ones
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge mclk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_read <= ~wr;
    avs_write <= wr;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Let the accept edge settle before callers look at outputs
    @(negedge mclk);
  endtask

  task automatic rd_cnt(output logic [15:0] v);
    bus(1'b0, IDX_COUNT_HI, 8'h00);
    v[15:8] = rd;
    bus(1'b0, IDX_COUNT_LO, 8'h00);
    v[7:0] = rd;
  endtask

  task automatic do_reset;
    @(posedge mclk);
    reset <= 1'b1;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
  endtask

  task automatic pulse(input logic [3:0] cap, input logic misc);
    @(posedge mclk);
    captureEdge <= cap;
    miscEvents <= '{misc, misc, misc};
    @(posedge mclk);
    captureEdge <= 4'h0;
    miscEvents <= '{1'b0, 1'b0, 1'b0};
  endtask

  task automatic set_cmp(input int ch, input logic [15:0] t);
    bus(1'b1, IDX_CMP_BASE + 8'(2 * ch), t[15:8]);
    bus(1'b1, IDX_CMP_BASE + 8'(2 * ch + 1), t[7:0]);
  endtask

  task automatic t_resets;
    logic [7:0] idx [7] = '{8'h0c, 8'h0d, 8'h20, 8'h22, 8'h23, 8'h25, 8'h30};
    chk({portAOut, portAOe, 5'h0, timerIrq}, 16'h0, "pins after reset");
    foreach (idx[i]) begin
      bus(1'b0, idx[i], 8'h00);
      chk(rd, 8'h00, "reset value");
    end
    bus(1'b1, IDX_OC1_DATA, 8'hff);
    bus(1'b0, IDX_OC1_DATA, 8'h00);
    chk(rd, 8'hf8, "data low bits");
    $display("test resets done");
  endtask

  task automatic t_coherent;
    logic [15:0] a;
    rd_cnt(a);
    bus(1'b0, IDX_COUNT_LO, 8'h00);
    n_tests++;
    // A lone low read sees the live count, the paired one the latched byte
    if (8'(rd - a[7:0]) < 8'd2 || 8'(rd - a[7:0]) > 8'd8) begin
      n_errors++;
      $display("[FAIL] %0t latched low byte %h live %h", $time, a[7:0], rd);
    end
    $display("test coherent done");
  endtask

  task automatic t_compare;
    logic [15:0] c;
    rd_cnt(c);
    bus(1'b1, IDX_OC1_DATA, 8'hf8);
    bus(1'b1, IDX_OC1_MASK, 8'h80);
    bus(1'b1, IDX_ACTION, 8'h6f);
    bus(1'b1, IDX_ACC_CTRL, 8'h04);
    for (int k = 0; k < 5; k++) set_cmp(k, c + 16'd200);
    repeat (260) @(posedge mclk);
    chk(portAOut, 5'b11010, "pins first match");
    chk(portAOe, 5'b11111, "pin enables");
    bus(1'b0, IDX_FLAGS1, 8'h00);
    chk(rd, 8'hf0, "compare flags");
    pulse(4'hf, 1'b0);
    bus(1'b0, IDX_FLAGS1, 8'h00);
    chk(rd, 8'hff, "capture flags");
    chk(timerIrq, 1'b0, "irq masked");
    bus(1'b1, IDX_IRQ_EN1, 8'h01);
    chk(timerIrq, 1'b1, "capture irq");
    bus(1'b1, IDX_FLAGS1, 8'h00);
    bus(1'b0, IDX_FLAGS1, 8'h00);
    chk(rd, 8'hff, "zero write keeps flags");
    bus(1'b1, IDX_FLAGS1, 8'h01);
    chk(timerIrq, 1'b0, "irq after clear");
    bus(1'b1, IDX_IRQ_EN1, 8'h48);
    chk(timerIrq, 1'b1, "shared and compare irq");
    bus(1'b1, IDX_FLAGS1, 8'hbf);
    chk(timerIrq, 1'b1, "compare irq kept");
    rd_cnt(c);
    bus(1'b1, IDX_ACC_CTRL, 8'h00);
    bus(1'b1, IDX_ACTION, 8'h73);
    set_cmp(1, c + 16'd200);
    set_cmp(2, c + 16'd200);
    set_cmp(4, c + 16'd200);
    repeat (260) @(posedge mclk);
    chk(portAOut[3], 1'b0, "toggle with flag set");
    chk({portAOut[2], portAOut[0]}, 2'b11, "drive high");
    chk(portAOe[1], 1'b0, "disconnected pin");
    bus(1'b0, IDX_FLAGS1, 8'h00);
    chk(rd, 8'h68, "compare five flag");
    $display("test compare done");
  endtask

  task automatic t_overflow;
    logic [15:0] c;
    rd_cnt(c);
    repeat (int'(17'h10000 - {1'b0, c}) + 20) @(posedge mclk);
    bus(1'b0, IDX_FLAGS2, 8'h00);
    chk(rd, 8'h80, "overflow flag");
    pulse(4'h0, 1'b1);
    bus(1'b0, IDX_FLAGS2, 8'h00);
    chk(rd, 8'hf0, "misc flags");
    bus(1'b1, IDX_IRQ_EN1, 8'h00);
    chk(timerIrq, 1'b0, "overflow irq off");
    bus(1'b1, IDX_IRQ_EN2, 8'h80);
    chk(timerIrq, 1'b1, "overflow irq on");
    bus(1'b1, IDX_FLAGS2, 8'h80);
    chk(timerIrq, 1'b0, "overflow cleared");
    bus(1'b1, IDX_IRQ_EN2, 8'h40);
    chk(timerIrq, 1'b1, "periodic irq");
    bus(1'b1, IDX_FLAGS2, 8'hf0);
    bus(1'b0, IDX_FLAGS2, 8'h00);
    chk({rd, 7'h0, timerIrq}, 16'h0, "flags2 cleared");
    $display("test overflow done");
  endtask

  task automatic t_prescale(input logic [1:0] r);
    logic [15:0] a;
    logic [15:0] b;
    int          ca;
    int          e;
    do_reset();
    if (r == 2'd0) repeat (70) @(posedge mclk);
    bus(1'b1, IDX_IRQ_EN2, {6'h0, r == 2'd0 ? 2'd3 : r});
    bus(1'b1, IDX_IRQ_EN2, {6'h0, ~r});
    bus(1'b0, IDX_IRQ_EN2, 8'h00);
    chk(rd[1:0], r, "prescale write once");
    rd_cnt(a);
    ca = cyc;
    repeat (160) @(posedge mclk);
    rd_cnt(b);
    e = (cyc - ca) / (r == 2'd0 ? 1 : 4 << (r - 1));
    n_tests++;
    if (int'(b - a) > e + 1 || int'(b - a) < e - 1) begin
      n_errors++;
      $display("[FAIL] %0t count rate %0d exp %0d", $time, b - a, e);
    end
    $display("test prescale %0d done", r);
  endtask

  initial begin
    reset = 1'b1;
    avs_address = 10'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    captureEdge = 4'h0;
    miscEvents = '{1'b0, 1'b0, 1'b0};
    n_errors = 0;
    n_tests = 0;
    cyc = 0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    t_resets();
    t_coherent();
    t_compare();
    t_overflow();
    for (int r = 0; r < 4; r++) t_prescale(2'(r));
    close_out();
  end
endmodule

// *** verilog/tmoc_pkg.sv ***
// Package with register map, field layout and reset values of the compare timer core
package tmoc_pkg;
  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_OC1_MASK   = 8'h0c;
  localparam logic [7:0] IDX_OC1_DATA   = 8'h0d;
  localparam logic [7:0] IDX_COUNT_HI   = 8'h0e;
  localparam logic [7:0] IDX_COUNT_LO   = 8'h0f;
  localparam logic [7:0] IDX_CMP_BASE   = 8'h16;
  localparam logic [7:0] IDX_ACTION     = 8'h20;
  localparam logic [7:0] IDX_IRQ_EN1    = 8'h22;
  localparam logic [7:0] IDX_FLAGS1     = 8'h23;
  localparam logic [7:0] IDX_IRQ_EN2    = 8'h24;
  localparam logic [7:0] IDX_FLAGS2     = 8'h25;
  localparam logic [7:0] IDX_ACC_CTRL   = 8'h26;
  // ==========================================================================
  // Field positions and counts
  localparam int         NUM_CMP        = 5;
  localparam int         POS_SHARED_SEL = 2;
  localparam int         POS_OVF        = 7;
  localparam int         POS_SHARED     = 3;
  localparam logic [6:0] PRESCALE_WINDOW_CYC = 7'h40;
  localparam logic [3:0] PRESCALE_LAST [4] = '{4'h0, 4'h3, 4'h7, 4'hf};
  // ==========================================================================
  // Reset values
  localparam logic [15:0] RST_COUNT     = 16'h0000;
  localparam logic [15:0] RST_CMP       = 16'hffff;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [4:0]  RST_PINS      = 5'h00;

  typedef struct packed {
    logic [15:0]              count;
    logic [3:0]               div;
    logic                     tickDone;
    logic [NUM_CMP-1:0][15:0] cmp;
    logic [NUM_CMP-1:0]       inhibit;
    logic [4:0]               oc1Data;
    logic [4:0]               oc1Mask;
    logic [7:0]               actionCtrl;
    logic [7:0]               irqEn1;
    logic [7:0]               flags1;
    logic [3:0]               irqEn2;
    logic [1:0]               prescale;
    logic                     prescaleLocked;
    logic [6:0]               bootCnt;
    logic [3:0]               flags2;
    logic                     sharedSel;
    logic [7:0]               lowLatch;
    logic                     latchValid;
    logic [4:0]               pins;
    logic                     ack;
    logic [7:0]               rdata;
  } tmoc_state_t;

  typedef struct packed {
    logic periodic;
    logic accumOverflow;
    logic accumEdge;
  } tmoc_misc_events_t;
endpackage

// *** verilog/tmoc_timer_core.sv ***
// Free-running timer with five output compares, flags, masks and Avalon-MM slave
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Operation
// (R1) On compare-1 match copy data bits to port A where mask bit is one.
// (R2) Compare-1 data register holds bits 7..3; bits 2..0 read zero.
// (R3) 16-bit counter on prescaled clock, resets to zero, read-only.
// (R4) Counter high-byte read latches low byte for the following low read.
// (R5) Action pair 00 none, 01 toggle, 10 drive low, 11 drive high.
// (R6) Pairs for channels 2..5 at bits 7:6..1:0, mode above level.
// (R7) Channel 5 compares only while the shared select is zero.
// (R8) Compare flag with enable set requests an interrupt.
// (R9) Capture 1..3 flag with enable set requests an interrupt.
// (R10) Enable register 1 aligns bit for bit with flag register 1.
// (R11) Enable bit 3 serves capture 4 or compare 5 per select.
// (R12) Compare flag sets each time counter equals compare value.
// (R13) Capture flags 1..3 set on each detected active edge.
// (R14) Flag bit 3 set by capture 4 or compare 5 per select.
// (R15) Flags clear only by writing one; zero leaves them.
// (R16) Overflow flag sets when counter rolls from all ones to zero.
// (R17) Overflow flag with its enable set requests an interrupt.
// (R18) Upper four bits of enable register 2 align with flag register 2.
// (R19) Prescale select divides by 1, 4, 8 or 16.
// (R20) Prescale select accepts one write only within 64 cycles of reset.
// (R21) Low four bits of flag register 2 read zero.
// (R22) Every compare register is compared against the counter each cycle; here a match counts only on the cycle a new count is present.
// (R23) High-byte compare write suppresses that channel's match one cycle.
// (R24) Pin action happens on every match regardless of flag state.
// (R25) Compare-1 mask bits 7..3 map to port A pins 7..3.
// (R26) One interrupt line high when any enabled flag is set.
module tmoc_timer_core
  import tmoc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic [9:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic [3:0]        captureEdge,
  input  wire tmoc_misc_events_t miscEvents,
  output logic      [4:0]        portAOut,
  output logic      [4:0]        portAOe,
  output logic                   timerIrq
);
  tmoc_state_t        st_reg;
  tmoc_state_t        st_next;
  logic [7:0]         idx;
  logic               req;
  logic               accept;
  logic               wrByte;
  logic [7:0]         wdata;
  logic               tick;
  logic [NUM_CMP-1:0] match;
  logic [7:0]         set1;
  logic [3:0]         set2;
  logic [7:0]         rmux;
  logic [1:0]         pair;
  logic [2:0]         cmpSel;
  logic               cmpHit;

  // ==========================================================================
  // Bus decode
  assign idx             = avs_address[9:2];
  assign req             = avs_read | avs_write;
  assign accept          = req & st_reg.ack;
  assign wrByte          = accept & avs_write & avs_byteenable[0];
  assign wdata           = avs_writedata[7:0];
  // One wait cycle gives time to register read data
  assign avs_waitrequest = req & ~st_reg.ack;
  assign avs_readdata    = {24'h000000, st_reg.rdata};

  // ==========================================================================
  // Timebase and compares
  assign tick = (st_reg.div == PRESCALE_LAST[st_reg.prescale]); // R19

  // Match only on the cycle a new count is present, else a slow
  // prescale would repeat toggle actions on one count value
  always_comb begin
    for (int i = 0; i < NUM_CMP; i++) begin
      match[i] = st_reg.tickDone && (st_reg.count == st_reg.cmp[i]) // R22
                 && !st_reg.inhibit[i]; // R23
    end
    match[4] = match[4] & ~st_reg.sharedSel; // R7
  end

  assign set1 = {match[0], match[1], match[2], match[3], // R12
                 st_reg.sharedSel ? captureEdge[3] : match[4], // R14
                 captureEdge[0], captureEdge[1], captureEdge[2]}; // R13
  assign set2 = {tick && (st_reg.count == 16'hffff), // R16
                 miscEvents.periodic, miscEvents.accumOverflow, miscEvents.accumEdge};

  // ==========================================================================
  // Read mux
  always_comb begin
    // Shift before the cut, else the fifth pair aliases onto the first
    cmpSel = 3'((idx - IDX_CMP_BASE) >> 1);
    cmpHit = (idx >= IDX_CMP_BASE) && (idx < IDX_CMP_BASE + 8'(2 * NUM_CMP));
    rmux   = RST_BYTE;
    case (idx)
      IDX_OC1_MASK: rmux = {st_reg.oc1Mask, 3'b000};
      IDX_OC1_DATA: rmux = {st_reg.oc1Data, 3'b000}; // R2
      IDX_COUNT_HI: rmux = st_reg.count[15:8];
      IDX_COUNT_LO: rmux = st_reg.latchValid ? st_reg.lowLatch : st_reg.count[7:0]; // R4
      IDX_ACTION:   rmux = st_reg.actionCtrl;
      IDX_IRQ_EN1:  rmux = st_reg.irqEn1;
      IDX_FLAGS1:   rmux = st_reg.flags1;
      IDX_IRQ_EN2:  rmux = {st_reg.irqEn2, 2'b00, st_reg.prescale};
      IDX_FLAGS2:   rmux = {st_reg.flags2, 4'h0}; // R21
      IDX_ACC_CTRL: rmux = {5'h00, st_reg.sharedSel, 2'b00};
      default: begin
        if (cmpHit) begin
          rmux = idx[0] ? st_reg.cmp[cmpSel][7:0] : st_reg.cmp[cmpSel][15:8];
        end
      end
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    st_next          = st_reg;
    st_next.ack      = req & ~st_reg.ack;
    st_next.tickDone = tick;
    st_next.inhibit  = '0;
    if (req && !st_reg.ack) begin
      st_next.rdata = avs_read ? rmux : RST_BYTE;
      // Low byte taken in the same cycle as the high byte it pairs with
      if (avs_read && idx == IDX_COUNT_HI) begin
        st_next.lowLatch = st_reg.count[7:0]; // R4
      end
    end
    if (st_reg.bootCnt != PRESCALE_WINDOW_CYC) begin
      st_next.bootCnt = st_reg.bootCnt + 7'h01;
    end

    // Counter advances only on prescaled ticks; bus cannot write it
    if (tick) begin
      st_next.div   = 4'h0;
      st_next.count = st_reg.count + 16'h0001; // R3
    end else begin
      st_next.div   = st_reg.div + 4'h1;
    end

    // Pin actions run on every match, whatever the flags hold
    for (int j = 0; j < 4; j++) begin
      pair = st_reg.actionCtrl[7-2*j -: 2]; // R6
      if (match[j+1]) begin // R24
        case (pair) // R5
          2'b01:   st_next.pins[3-j] = ~st_reg.pins[3-j];
          2'b10:   st_next.pins[3-j] = 1'b0;
          2'b11:   st_next.pins[3-j] = 1'b1;
          default: st_next.pins[3-j] = st_reg.pins[3-j];
        endcase
      end
    end
    // Compare 1 wins over the per-channel actions on shared pins
    if (match[0]) begin
      st_next.pins = (st_next.pins & ~st_reg.oc1Mask) // R1
                     | (st_reg.oc1Data & st_reg.oc1Mask); // R25
    end

    if (accept) begin
      st_next.latchValid = 1'b0;
    end
    if (accept && avs_read && idx == IDX_COUNT_HI) begin
      st_next.latchValid = 1'b1; // R4
    end

    // Flags: clear by one, set wins in the same cycle
    st_next.flags1 = st_reg.flags1;
    st_next.flags2 = st_reg.flags2;
    if (wrByte && idx == IDX_FLAGS1) begin
      st_next.flags1 = st_reg.flags1 & ~wdata; // R15
    end
    if (wrByte && idx == IDX_FLAGS2) begin
      st_next.flags2 = st_reg.flags2 & ~wdata[7:4]; // R15
    end
    st_next.flags1 = st_next.flags1 | set1;
    st_next.flags2 = st_next.flags2 | set2;

    if (wrByte) begin
      case (idx)
        IDX_OC1_MASK: st_next.oc1Mask    = wdata[7:3];
        IDX_OC1_DATA: st_next.oc1Data    = wdata[7:3]; // R2
        IDX_ACTION:   st_next.actionCtrl = wdata;
        IDX_IRQ_EN1:  st_next.irqEn1     = wdata; // R10
        IDX_IRQ_EN2: begin
          st_next.irqEn2 = wdata[7:4]; // R18
          if (!st_reg.prescaleLocked && st_reg.bootCnt != PRESCALE_WINDOW_CYC) begin
            st_next.prescale       = wdata[1:0]; // R20
            st_next.prescaleLocked = 1'b1;
          end
        end
        IDX_ACC_CTRL: st_next.sharedSel  = wdata[POS_SHARED_SEL];
        default: begin
          if (cmpHit) begin
            if (idx[0]) begin
              st_next.cmp[cmpSel][7:0] = wdata;
            end else begin
              st_next.cmp[cmpSel][15:8] = wdata;
              st_next.inhibit[cmpSel]   = 1'b1; // R23
            end
          end
        end
      endcase
    end
    // Window closes for good once it runs out
    if (st_reg.bootCnt == PRESCALE_WINDOW_CYC) begin
      st_next.prescaleLocked = 1'b1; // R20
    end

    if (reset) begin
      st_next.count          = RST_COUNT;
      st_next.div            = 4'h0;
      st_next.tickDone       = 1'b0;
      st_next.cmp            = {NUM_CMP{RST_CMP}};
      st_next.inhibit        = '0;
      st_next.oc1Data        = 5'h00;
      st_next.oc1Mask        = 5'h00;
      st_next.actionCtrl     = RST_BYTE;
      st_next.irqEn1         = RST_BYTE;
      st_next.flags1         = RST_BYTE;
      st_next.irqEn2         = 4'h0;
      st_next.prescale       = 2'b00;
      st_next.prescaleLocked = 1'b0;
      st_next.bootCnt        = 7'h00;
      st_next.flags2         = 4'h0;
      st_next.sharedSel      = 1'b0;
      st_next.lowLatch       = RST_BYTE;
      st_next.latchValid     = 1'b0;
      st_next.pins           = RST_PINS;
      st_next.ack            = 1'b0;
      st_next.rdata          = RST_BYTE;
    end
  end

  always_ff @(posedge mclk) begin
    st_reg <= st_next;
  end

  // ==========================================================================
  // Outputs
  assign portAOut = st_reg.pins;
  always_comb begin
    for (int j = 0; j < 4; j++) begin
      portAOe[3-j] = st_reg.oc1Mask[3-j] | (st_reg.actionCtrl[7-2*j -: 2] != 2'b00);
    end
    portAOe[4] = st_reg.oc1Mask[4];
  end
  // Bit 3 enable follows the flag's source, so one AND covers both uses
  assign timerIrq = |(st_reg.flags1 & st_reg.irqEn1) // R8 R9 R11
                    | |(st_reg.flags2 & st_reg.irqEn2); // R17 R26

  // ==========================================================================
  // Assertions
  a_count_advance: assert property (@(posedge mclk) disable iff (reset) // R3
    !$past(tick) && !$past(reset) |-> st_reg.count == $past(st_reg.count))
    else $error("counter moved without a tick");

  a_overflow_set: assert property (@(posedge mclk) disable iff (reset) // R16
    tick && st_reg.count == 16'hffff |=> st_reg.flags2[3] && st_reg.count == 16'h0000)
    else $error("overflow flag not set on rollover");

  a_oc1_pins: assert property (@(posedge mclk) disable iff (reset) // R1
    match[0] |=> ((st_reg.pins ^ $past(st_reg.oc1Data)) & $past(st_reg.oc1Mask)) == 5'h00)
    else $error("compare 1 pin data not applied");

  a_data_lowbits: assert property (@(posedge mclk) disable iff (reset) // R2
    accept && avs_read && idx == IDX_OC1_DATA |-> avs_readdata[2:0] == 3'b000)
    else $error("unimplemented data bits read nonzero");

  a_high_inhibit: assert property (@(posedge mclk) disable iff (reset) // R23
    wrByte && cmpHit && !idx[0] |=> !match[$past(cmpSel)])
    else $error("compare not suppressed after high write");

  a_prescale_once: assert property (@(posedge mclk) disable iff (reset) // R20
    st_reg.prescaleLocked |=> $stable(st_reg.prescale))
    else $error("prescale changed after lock");

  a_flag_w1c: assert property (@(posedge mclk) disable iff (reset) // R15
    wrByte && idx == IDX_FLAGS1 && wdata[7] && !set1[7] ##1 !match[0] |-> !st_reg.flags1[7])
    else $error("flag not cleared by writing one");

  a_ch5_gate: assert property (@(posedge mclk) disable iff (reset) // R7
    st_reg.sharedSel |-> !match[4])
    else $error("compare 5 active while capture selected");

  a_irq_enabled: assert property (@(posedge mclk) disable iff (reset) // R8
    st_reg.flags1[7] && st_reg.irqEn1[7] |-> timerIrq)
    else $error("enabled compare flag gave no interrupt");

  a_coherent_read: assert property (@(posedge mclk) disable iff (reset) // R4
    accept && avs_read && idx == IDX_COUNT_HI |=> st_reg.latchValid
      && st_reg.lowLatch == $past(st_reg.count[7:0], 2))
    else $error("low byte not latched on high read");
endmodule
